// >>> core/ccs_pkg.sv
// Package with register map, field positions, reset values and timing constants of the clock select block.
package ccs_pkg;

    // ==========================================================================
    // Register map
    localparam logic [15:0] CCS_PIN_MODE_ADDR  = 16'hFF9F;
    localparam logic [15:0] CCS_CPU_CTRL_ADDR  = 16'hFFFB;
    localparam logic [15:0] CCS_STATUS_ADDR    = 16'h0000;
    localparam logic [7:0]  CCS_PIN_MODE_RESET = 8'h00;
    localparam logic [7:0]  CCS_CPU_CTRL_RESET = 8'h01;

    // ==========================================================================
    // Field positions
    localparam int CCS_HS_EXT_BIT    = 7;
    localparam int CCS_HS_PIN_BIT    = 6;
    localparam int CCS_SUB_EXT_BIT   = 5;
    localparam int CCS_SUB_PIN_BIT   = 4;
    localparam int CCS_GAIN_BIT      = 0;
    localparam int CCS_XT_START_BIT  = 6;
    localparam int CCS_CPU_STATUS_BIT = 5;
    localparam int CCS_SOURCE_BIT     = 4;
    localparam logic [7:0] CCS_PIN_MODE_MASK = 8'hF1;
    localparam logic [7:0] CCS_CPU_CTRL_MASK = 8'h57;

    // ==========================================================================
    // Timing
    localparam int CCS_CLK_MHZ        = 25;
    localparam int CCS_GAIN_HOLD_US   = 5;
    localparam int CCS_GAIN_HOLD_CYC  = CCS_GAIN_HOLD_US * CCS_CLK_MHZ;
    localparam int CCS_OST_CYC_DEFAULT = 256;
    localparam int CCS_INSTR_CLOCKS   = 2;

    typedef enum logic [1:0] {CCS_HS_PORT, CCS_HS_CRYSTAL, CCS_HS_EXTERNAL} ccs_hs_mode_t;
    typedef enum logic [1:0] {CCS_SUB_PORT, CCS_SUB_CRYSTAL, CCS_SUB_EXTERNAL} ccs_sub_mode_t;

endpackage : ccs_pkg

// >>> core/ccs_clock_select.sv
// Clock pin mode and CPU clock select logic with an AXI4-Lite register slave.
//
// Function
// - The pin mode register resets to zero; only bits 7 to 4 and the gain bit are written, when write strobe bit 0 is set.
// - The high-speed pin field gives port for 00 and 10, crystal for 01 and external clock for 11.
// - The gain band bit takes only one change after reset and is set before peripherals.
// - Writing the gain band bit to one gates the CPU clock off for at least five microseconds.
// - Leaving stop with gain band one on the main clock holds the CPU five microseconds, or the stabilization time on crystal.
// - The CPU clock control register resets to 01H, main clock divided by two.
// - The read-only status bit shows zero on the main clock and one on the subsystem clock.
// - Divider codes 000 to 100 give main clock over 1 to 16, or subsystem over two when source is one.
// - The minimum instruction time is two periods of the selected CPU clock.
// - The subsystem pin mode is crystal if crystal start is set, else decoded from the two mode bits.
`timescale 1ns/1ps
module ccs_clock_select
    import ccs_pkg::*;
#(
    parameter int OST_CYCLES = CCS_OST_CYC_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        stopRelease,
    input  wire logic        mainIsCrystal,
    input  wire logic        mainClkTick,
    input  wire logic        subClkTick,
    output logic [1:0]       hsPinMode,
    output logic [1:0]       subPinMode,
    output logic             cpuClockEnable,
    output logic             cpuClockHold,
    output logic             instrSlot
);

    if (OST_CYCLES < 1 || OST_CYCLES > 65535) begin : g_ost_range
        $error("OST_CYCLES out of range");
    end

    localparam logic [15:0] GAIN_HOLD = 16'(CCS_GAIN_HOLD_CYC);
    localparam logic [15:0] OST_HOLD  = 16'(OST_CYCLES);

    // ==========================================================================
    // State
    typedef struct packed {
        logic        awHeld;
        logic [15:0] awAddr;
        logic        wHeld;
        logic [7:0]  wData;
        logic        wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [7:0]  pinMode;
        logic [6:0]  cpuCtrl;
        logic        gainChanged;
        logic [15:0] holdCount;
        logic        subActive;
        logic [3:0]  activeDiv;
        logic [3:0]  divCount;
        logic        slot;
        logic        stopSync0;
        logic        stopSync1;
        logic        stopSeen;
        logic        instrPhase;
    } ccs_state_t;

    ccs_state_t state;
    ccs_state_t next_state;

    logic       doWrite;
    logic       doRead;
    logic       tick;
    logic [3:0] reqDiv;
    logic [7:0] cpuRead;
    logic       stopRise;
    logic       holdLoad;

    // ==========================================================================
    // Combinational next state
    always_comb begin
        next_state = state;
        holdLoad   = 1'b0;
        stopRise   = state.stopSync1 & ~state.stopSeen;
        next_state.stopSync0 = stopRelease;
        next_state.stopSync1 = state.stopSync0;
        next_state.stopSeen  = state.stopSync1;
        cpuRead = {1'b0, state.cpuCtrl[6], state.subActive, state.cpuCtrl[4:0]};

        if (s_axi_awvalid && !state.awHeld) begin
            next_state.awHeld = 1'b1;
            next_state.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.wHeld) begin
            next_state.wHeld = 1'b1;
            next_state.wData = s_axi_wdata[7:0];
            next_state.wStrb = s_axi_wstrb[0];
        end
        doWrite = state.awHeld && state.wHeld && !state.bValid;
        if (doWrite) begin
            next_state.awHeld = 1'b0;
            next_state.wHeld  = 1'b0;
            next_state.bValid = 1'b1;
            next_state.bResp  = 2'h0;
            if (state.awAddr == CCS_PIN_MODE_ADDR) begin
                if (state.wStrb) begin
                    next_state.pinMode[7:4] = state.wData[7:4];
                    if (!state.gainChanged && state.wData[CCS_GAIN_BIT] != state.pinMode[CCS_GAIN_BIT]) begin
                        next_state.pinMode[CCS_GAIN_BIT] = state.wData[CCS_GAIN_BIT];
                        next_state.gainChanged = 1'b1;
                        if (state.wData[CCS_GAIN_BIT]) begin
                            next_state.holdCount = GAIN_HOLD;
                            holdLoad             = 1'b1;
                        end
                    end
                end
            end else if (state.awAddr == CCS_CPU_CTRL_ADDR) begin
                if (state.wStrb) begin
                    next_state.cpuCtrl[6]   = state.wData[6];
                    next_state.cpuCtrl[4:0] = state.wData[4:0];
                end
            end else if (state.awAddr != CCS_STATUS_ADDR) begin
                next_state.bResp = 2'h2;
            end
        end
        if (state.bValid && s_axi_bready) begin
            next_state.bValid = 1'b0;
        end

        doRead = s_axi_arvalid && !state.rValid;
        if (doRead) begin
            next_state.rValid = 1'b1;
            next_state.rResp  = 2'h0;
            unique case (s_axi_araddr)
                CCS_PIN_MODE_ADDR: next_state.rData = {24'h000000, state.pinMode};
                CCS_CPU_CTRL_ADDR: next_state.rData = {24'h000000, cpuRead};
                CCS_STATUS_ADDR:   next_state.rData = {24'h000000, 3'h0, state.activeDiv, state.gainChanged};
                default: begin
                    next_state.rData = 32'h00000000;
                    next_state.rResp = 2'h2;
                end
            endcase
        end else if (state.rValid && s_axi_rready) begin
            next_state.rValid = 1'b0;
        end

        if (stopRise && state.pinMode[CCS_GAIN_BIT] && !state.subActive) begin
            next_state.holdCount = mainIsCrystal ? OST_HOLD : GAIN_HOLD;
            holdLoad             = 1'b1;
        end else if (!holdLoad && state.holdCount != 16'h0000) begin
            next_state.holdCount = state.holdCount - 16'h0001;
        end

        // Legal codes select a divide-by power; prohibited codes keep the running setting.
        unique case ({state.cpuCtrl[CCS_SOURCE_BIT], state.cpuCtrl[2:0]})
            4'h0: reqDiv = 4'h0;
            4'h1: reqDiv = 4'h1;
            4'h2: reqDiv = 4'h3;
            4'h3: reqDiv = 4'h7;
            4'h4: reqDiv = 4'hF;
            4'h8, 4'h9, 4'hA, 4'hB, 4'hC: reqDiv = 4'h1;
            default: reqDiv = state.activeDiv;
        endcase

        tick = state.subActive ? subClkTick : mainClkTick;
        next_state.slot = 1'b0;
        if (state.slot) begin
            next_state.instrPhase = ~state.instrPhase;
        end
        // A hold that starts in this cycle also cancels the pulse that would end here, so none slips out.
        if (tick && state.holdCount == 16'h0000 && !holdLoad) begin
            if (state.divCount == 4'h0) begin
                // A new source or ratio is taken only at the end of a whole period.
                next_state.divCount  = reqDiv;
                next_state.activeDiv = reqDiv;
                next_state.subActive = state.cpuCtrl[CCS_SOURCE_BIT];
                next_state.slot      = 1'b1;
            end else begin
                next_state.divCount = state.divCount - 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state         <= '0;
            state.pinMode <= CCS_PIN_MODE_RESET;
            state.cpuCtrl <= CCS_CPU_CTRL_RESET[6:0];
            state.activeDiv <= 4'h1;
            state.divCount  <= 4'h1;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================================
    // Outputs
    assign s_axi_awready  = ~state.awHeld;
    assign s_axi_wready   = ~state.wHeld;
    assign s_axi_bvalid   = state.bValid;
    assign s_axi_bresp    = state.bResp;
    assign s_axi_arready  = ~state.rValid;
    assign s_axi_rvalid   = state.rValid;
    assign s_axi_rdata    = state.rData;
    assign s_axi_rresp    = state.rResp;
    assign cpuClockEnable = state.slot;
    assign cpuClockHold   = state.holdCount != 16'h0000;
    assign instrSlot      = state.slot & state.instrPhase;

    always_comb begin
        unique case ({state.pinMode[CCS_HS_EXT_BIT], state.pinMode[CCS_HS_PIN_BIT]})
            2'b01:   hsPinMode = 2'(CCS_HS_CRYSTAL);
            2'b11:   hsPinMode = 2'(CCS_HS_EXTERNAL);
            2'b00, 2'b10: hsPinMode = 2'(CCS_HS_PORT);
        endcase
        if (state.cpuCtrl[CCS_XT_START_BIT]) begin
            subPinMode = 2'(CCS_SUB_CRYSTAL);
        end else begin
            unique case ({state.pinMode[CCS_SUB_EXT_BIT], state.pinMode[CCS_SUB_PIN_BIT]})
                2'b01:   subPinMode = 2'(CCS_SUB_CRYSTAL);
                2'b11:   subPinMode = 2'(CCS_SUB_EXTERNAL);
                2'b00, 2'b10: subPinMode = 2'(CCS_SUB_PORT);
            endcase
        end
    end

    // ==========================================================================
    // Assertions
    property p_gain_hold;
        @(posedge clk) disable iff (reset)
        (doWrite && state.awAddr == CCS_PIN_MODE_ADDR && next_state.holdCount == GAIN_HOLD
         && !state.pinMode[CCS_GAIN_BIT] && state.wData[CCS_GAIN_BIT] && state.wStrb)
        |=> !cpuClockEnable [*8];
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("CPU clock ran during gain hold");

    property p_gain_once;
        @(posedge clk) disable iff (reset)
        $past(state.gainChanged) |-> $stable(state.pinMode[CCS_GAIN_BIT]);
    endproperty
    a_gain_once: assert property (p_gain_once) else $error("Gain bit changed twice");

    property p_status_bit;
        @(posedge clk) disable iff (reset)
        state.slot |-> cpuRead[CCS_CPU_STATUS_BIT] == $past(state.cpuCtrl[CCS_SOURCE_BIT]);
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("Status bit wrong");

    property p_hs_ext;
        @(posedge clk) disable iff (reset)
        (state.pinMode[7:6] == 2'b10) |-> hsPinMode == 2'(CCS_HS_PORT);
    endproperty
    a_hs_ext: assert property (p_hs_ext) else $error("Pin mode decode wrong");

    property p_sub_start;
        @(posedge clk) disable iff (reset)
        state.cpuCtrl[CCS_XT_START_BIT] |-> subPinMode == 2'(CCS_SUB_CRYSTAL);
    endproperty
    a_sub_start: assert property (p_sub_start) else $error("Sub pin decode wrong");

    property p_no_short;
        @(posedge clk) disable iff (reset)
        (tick && state.holdCount == 16'h0000 && state.divCount != 4'h0) |=> $stable(state.subActive);
    endproperty
    a_no_short: assert property (p_no_short) else $error("Source switched mid period");

    property p_stop_hold;
        @(posedge clk) disable iff (reset)
        (stopRise && state.pinMode[CCS_GAIN_BIT] && !state.subActive) |=> cpuClockHold [*8];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("No hold after stop");

    property p_reset_div;
        @(posedge clk) disable iff (reset)
        $rose(state.slot) && !$past(state.subActive) && $past(state.cpuCtrl[4:0]) == 5'h01
        |-> state.activeDiv == 4'h1;
    endproperty
    a_reset_div: assert property (p_reset_div) else $error("Divider code one not halving");

    property p_hold_gate;
        @(posedge clk) disable iff (reset)
        cpuClockHold |-> !cpuClockEnable;
    endproperty
    a_hold_gate: assert property (p_hold_gate) else $error("CPU clock pulse during hold");

    property p_read_upper;
        @(posedge clk) disable iff (reset)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("Upper read bits not zero");

    property p_hs_crystal;
        @(posedge clk) disable iff (reset)
        (state.pinMode[7:6] == 2'b01) |-> hsPinMode == 2'(CCS_HS_CRYSTAL);
    endproperty
    a_hs_crystal: assert property (p_hs_crystal) else $error("Crystal pin mode decode wrong");

    property p_sub_ext;
        @(posedge clk) disable iff (reset)
        (!state.cpuCtrl[CCS_XT_START_BIT] && state.pinMode[5:4] == 2'b11) |-> subPinMode == 2'(CCS_SUB_EXTERNAL);
    endproperty
    a_sub_ext: assert property (p_sub_ext) else $error("Sub external decode wrong");

    property p_div_sixteen;
        @(posedge clk) disable iff (reset)
        $rose(state.slot) && $past(state.cpuCtrl[4:0]) == 5'h04 |-> state.activeDiv == 4'hF;
    endproperty
    a_div_sixteen: assert property (p_div_sixteen) else $error("Divider code four not by sixteen");

    property p_sub_div;
        @(posedge clk) disable iff (reset)
        $rose(state.slot) && $past(state.cpuCtrl[CCS_SOURCE_BIT]) && $past(state.cpuCtrl[2:0]) <= 3'h4
        |-> state.subActive && state.activeDiv == 4'h1;
    endproperty
    a_sub_div: assert property (p_sub_div) else $error("Subsystem clock not halved");

    property p_crystal_load;
        @(posedge clk) disable iff (reset)
        (stopRise && state.pinMode[CCS_GAIN_BIT] && !state.subActive && mainIsCrystal)
        |=> state.holdCount == OST_HOLD;
    endproperty
    a_crystal_load: assert property (p_crystal_load) else $error("Stabilization hold not loaded");

    property p_main_load;
        @(posedge clk) disable iff (reset)
        (stopRise && state.pinMode[CCS_GAIN_BIT] && !state.subActive && !mainIsCrystal)
        |=> state.holdCount == GAIN_HOLD;
    endproperty
    a_main_load: assert property (p_main_load) else $error("Stop hold not loaded");

endmodule : ccs_clock_select

// >>> verif/ccs_clock_source.sv
// Behavioural model of the main and subsystem clock sources seen as tick pulses.
`timescale 1ns/1ps
module ccs_clock_source #(
    parameter int MAIN_DIV = 2,
    parameter int SUB_DIV  = 5
) (
    input  wire logic clk,
    input  wire logic reset,
    output logic      mainClkTick,
    output logic      subClkTick
);
    // ==========================================================================
    // Tick generation
    // Uneven divisors keep the two sources out of step, as real oscillators are.
    int mainCnt;
    int subCnt;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mainCnt     <= 0;
            subCnt      <= 0;
            mainClkTick <= 1'b0;
            subClkTick  <= 1'b0;
        end else begin
            mainCnt     <= (mainCnt == MAIN_DIV - 1) ? 0 : mainCnt + 1;
            subCnt      <= (subCnt == SUB_DIV - 1) ? 0 : subCnt + 1;
            mainClkTick <= (mainCnt == MAIN_DIV - 1);
            subClkTick  <= (subCnt == SUB_DIV - 1);
        end
    end
endmodule : ccs_clock_source

// >>> verif/test_ccs_clock_select.sv
// Self-checking testbench of the clock pin mode and CPU clock select block.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ccs_clock_select;
    import ccs_pkg::*;
    localparam int OST = 8;
    localparam int MDIV = 2;
    localparam int SDIV = 5;
    logic clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, hsPinMode, subPinMode;
    logic awready, wready, bvalid, arready, rvalid, mainClkTick, subClkTick;
    logic stopRelease = 1'b0, mainIsCrystal = 1'b0, cpuClockEnable, cpuClockHold, instrSlot;
    int errors = 0, total_checks = 0;
    logic [7:0] rd, v, cc;
    logic [1:0] rs;
    int p, q, h, e;
    always #20 clk = ~clk;
    ccs_clock_source #(.MAIN_DIV(MDIV), .SUB_DIV(SDIV)) ccs_clock_source_i (.clk(clk), .reset(reset),
        .mainClkTick(mainClkTick), .subClkTick(subClkTick));
    ccs_clock_select #(.OST_CYCLES(OST)) ccs_clock_select_i (.clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .stopRelease(stopRelease), .mainIsCrystal(mainIsCrystal),
        .mainClkTick(mainClkTick), .subClkTick(subClkTick), .hsPinMode(hsPinMode),
        .subPinMode(subPinMode), .cpuClockEnable(cpuClockEnable), .cpuClockHold(cpuClockHold),
        .instrSlot(instrSlot));
    // ==========================================================================
    // Bus tasks
    task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
        bit aw, w;
        int n;
        aw = 0; w = 0; n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'h1; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw && w) && n < 100) begin
            @(posedge clk); n++;
            if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 1'b0; end
            if (!w && wready === 1'b1) begin w = 1; wvalid <= 1'b0; end
        end
        do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 200);
        if (bvalid !== 1'b1) errors++;
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [15:0] a, output logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 200) begin @(posedge clk); n++; end
        if (rvalid !== 1'b1) errors++;
        d = rdata[7:0]; r = rresp;
        `CHK(rdata[31:8], 24'h0)
        rready <= 1'b0;
    endtask : rdr
    // ==========================================================================
    // Measurement tasks and expectations
    task automatic gap(input bit s, output int c);
        int n;
        n = 0; c = 0;
        do begin @(posedge clk); n++; end while ((s ? instrSlot : cpuClockEnable) !== 1'b1 && n < 5000);
        do begin @(posedge clk); c++; end while ((s ? instrSlot : cpuClockEnable) !== 1'b1 && c < 5000);
    endtask : gap
    task automatic hold(output int c, output int en);
        int n;
        n = 0; c = 0; en = 0;
        while (cpuClockHold !== 1'b1 && n < 20) begin @(posedge clk); n++; end
        while (cpuClockHold === 1'b1 && c < 5000) begin @(posedge clk); c++; if (cpuClockEnable) en++; end
    endtask : hold
    function automatic logic [1:0] pinExp(input logic xt, input logic [1:0] f);
        return xt ? 2'd1 : (f == 2'b01) ? 2'd1 : (f == 2'b11) ? 2'd2 : 2'd0;
    endfunction : pinExp
    task conclude;
        $display("Counts: %0d checks, %0d mismatches", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    // ==========================================================================
    // Watchdog sized well above the longest expected sequence.
    initial begin
        #(40 * 60000);
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(42754));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdr(CCS_PIN_MODE_ADDR, rd, rs); `CHK(rd, 8'h00)
        rdr(CCS_CPU_CTRL_ADDR, rd, rs); `CHK(rd, 8'h01)
        rdr(16'h1234, rd, rs); `CHK(rs, 2'b10)
        `CHK(rd, 8'h00)
        wr(16'h1234, 8'hFF, rs); `CHK(rs, 2'b10)
        $display("reset and unmapped test done");
        // Gain bit stays zero here so that its single change is spent later.
        for (int i = 0; i < 8; i++) begin
            v = {i[1:0], 2'($urandom), 4'h0};
            cc = {1'b0, 1'($urandom), 6'h01};
            wr(CCS_PIN_MODE_ADDR, v | 8'h0E, rs);
            wr(CCS_CPU_CTRL_ADDR, cc, rs);
            rdr(CCS_PIN_MODE_ADDR, rd, rs); `CHK(rd, v & CCS_PIN_MODE_MASK)
            `CHK(hsPinMode, pinExp(1'b0, v[7:6]))
            `CHK(subPinMode, pinExp(cc[6], v[5:4]))
        end
        $display("pin mode test done");
        for (int k = 0; k < 6; k++) begin
            cc = (k < 5) ? {3'b000, 1'b0, 1'b0, 3'(k)} : {3'b000, 1'b1, 1'b0, 3'($urandom_range(4))};
            wr(CCS_CPU_CTRL_ADDR, cc | {2'b00, 1'($urandom), 5'h00}, rs);
            gap(0, p); gap(0, p); gap(1, q);
            rdr(CCS_CPU_CTRL_ADDR, rd, rs); `CHK(rd, cc | {2'b00, cc[4], 5'h00})
            `CHK(p, (k < 5) ? MDIV * (1 << k) : SDIV * 2)
            `CHK(q, 2 * p)
        end
        $display("divider test done");
        wr(CCS_CPU_CTRL_ADDR, 8'h01, rs);
        wr(CCS_PIN_MODE_ADDR, 8'h01, rs);
        hold(h, e); `CHK(h >= CCS_GAIN_HOLD_CYC, 1'b1)
        `CHK(e, 0)
        wr(CCS_PIN_MODE_ADDR, 8'h00, rs);
        rdr(CCS_PIN_MODE_ADDR, rd, rs); `CHK(rd, 8'h01)
        rdr(CCS_STATUS_ADDR, rd, rs); `CHK(rd, 8'h03)
        $display("gain test done");
        for (int m = 0; m < 2; m++) begin
            mainIsCrystal <= 1'(m);
            stopRelease <= 1'b1;
            hold(h, e); `CHK(h >= (m ? OST : CCS_GAIN_HOLD_CYC), 1'b1)
            `CHK(e, 0)
            stopRelease <= 1'b0;
            repeat (4) @(posedge clk);
        end
        $display("stop release test done");
        conclude();
    end
endmodule : test_ccs_clock_select
